// file: common/asp_consts.svh
// Constants for the analog sample packer
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

`define ASP_WORD_W       16
`define ASP_WORD_BITS    7'h10
`define ASP_SAMP_MAX_W   64
`define ASP_ACC_W        80
`define ASP_CNT_W        7
`define ASP_NCH          8
`define ASP_MAX_WORDS    65536
`define ASP_MODE_PACK    0
`define ASP_MODE_LSBPAD  2'h1
`define ASP_LEN_FULL     6'h00
`define ASP_LEN_FULL_W   7'h40
`define ASP_PAD_ROUND    7'h0F
`define ASP_PAD_MASK     7'h70
`define ASP_CSW_BITS     7'h20
`define ASP_TS_BITS      7'h40
`define ASP_EVT_BITS     7'h20
`define ASP_DLEN_FULL    5'h00
`define ASP_CSW_RSV      4'h0
`define ASP_DCSW_RSV     24'h000000

`endif

// file: common/asp_pkg.sv
// Types for the analog sample packer
package asp_pkg;

	typedef struct packed {
		logic [3:0] factor;
		logic [5:0] length;
	} asp_chan_cfg_t;

	typedef struct packed {
		logic [2:0] mode;
		logic [4:0] length;
	} asp_disc_cfg_t;

	typedef struct packed {
		logic [63:0] stamp;
		logic [31:0] states;
		logic        last;
	} asp_evt_t;

	typedef enum logic [5:0] {
		ASP_S_IDLE  = 6'h01,
		ASP_S_CSW   = 6'h02,
		ASP_S_SAMP  = 6'h04,
		ASP_S_STAMP = 6'h08,
		ASP_S_STATE = 6'h10,
		ASP_S_FLUSH = 6'h20
	} asp_state_t;

endpackage : asp_pkg

// file: hw/asp_bit_packer.sv
// Bit accumulator that turns variable-width fields into 16-bit words
`timescale 1ns/1ps
`include "asp_consts.svh"

module asp_bit_packer #(
	parameter int ACC_W = `ASP_ACC_W
) (
	input  wire logic              clk_sys_i,
	input  wire logic              nrst_i,
	input  wire logic              in_valid_i,
	output logic                   in_ready_o,
	input  wire logic [63:0]       in_data_i,
	input  wire logic [6:0]        in_bits_i,
	input  wire logic              flush_i,
	output logic                   out_valid_o,
	input  wire logic              out_ready_i,
	output logic [15:0]            out_data_o,
	output logic                   out_last_o,
	output logic                   empty_o
);

	logic [ACC_W-1:0]      acc_r;
	logic [ACC_W-1:0]      acc_nxt;
	logic [`ASP_CNT_W-1:0] cnt_r;
	logic [`ASP_CNT_W-1:0] cnt_nxt;
	logic [63:0]           in_mask;
	logic                  pop;
	logic                  push;

	// Room for a full 64-bit field once fewer than 16 bits wait
	assign in_ready_o  = (cnt_r < `ASP_WORD_BITS) && !flush_i;
	assign out_valid_o = (cnt_r >= `ASP_WORD_BITS) || (flush_i && (cnt_r != '0));
	assign out_last_o  = flush_i && (cnt_r != '0) && (cnt_r <= `ASP_WORD_BITS);
	assign out_data_o  = acc_r[15:0];
	assign empty_o     = (cnt_r == '0);
	assign pop         = out_valid_o && out_ready_i;
	assign push        = in_valid_i && in_ready_o;
	assign in_mask     = (in_bits_i == `ASP_LEN_FULL_W) ? '1 : ((64'h1 << in_bits_i) - 64'h1);

	always_comb
	begin
		acc_nxt = acc_r;
		cnt_nxt = cnt_r;
		if (pop)
		begin
			acc_nxt = acc_r >> `ASP_WORD_W;
			cnt_nxt = (cnt_r > `ASP_WORD_BITS) ? cnt_r - `ASP_WORD_BITS : '0;
		end
		else if (push)
		begin
			acc_nxt = acc_r | (ACC_W'(in_data_i & in_mask) << cnt_r);
			cnt_nxt = cnt_r + in_bits_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			acc_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			acc_r <= acc_nxt;
			cnt_r <= cnt_nxt;
		end
	end

endmodule : asp_bit_packer

// file: hw/asp_packer.sv
// Packet body formatter for analog sample and discrete event packets
//
// Operation
// - Simultaneous samples per schedule equal slowest enabled factor denominator.
// - Last simultaneous sample of a schedule holds every listed subchannel.
// - Within a simultaneous sample, subchannels go out in ascending order.
// - Any number of complete schedules, body kept within maximum length.
// - Unpacked mode pads each sample to the next 16-bit boundary.
// - Unpacked pad count is the next multiple of sixteen minus sample width.
// - Every unpacked pad bit is zero.
// - Msb-padded mode puts the sample in low bits of its word.
// - Lsb-padded mode puts the sample in high bits, zeros below.
// - Packed mode concatenates samples lsb-first, spilling into next word.
// - Packed body ends with zero filler in last word's upper bits.
// - Filler count is sixteen minus total data bits modulo sixteen.
// - Each 32-bit channel word goes low half first, before samples.
// - A discrete event records one to 32 input states.
// - Discrete body: channel word, then per event time stamp and states.
// - Discrete body starts with its single channel word.
// - Two-bit mode selects packed, lsb-padded or msb-padded for all.
// - Six-bit length gives sample width, zero meaning 64 bits.
// - Four-bit factor k divides primary rate by two to the k.
`timescale 1ns/1ps
`include "asp_consts.svh"

module asp_packer #(
	parameter int NCH       = `ASP_NCH,
	parameter int MAX_WORDS = `ASP_MAX_WORDS
) (
	input  wire logic                              clk_sys_i,
	input  wire logic                              nrst_i,
	input  wire logic                              start_i,
	input  wire logic                              discrete_i,
	input  wire logic [1:0]                        mode_i,
	input  wire logic [NCH-1:0]                    chan_en_i,
	input  wire asp_pkg::asp_chan_cfg_t [NCH-1:0]  chan_cfg_i,
	input  wire logic [15:0]                       sched_cnt_i,
	input  wire asp_pkg::asp_disc_cfg_t            disc_cfg_i,
	input  wire logic                              samp_valid_i,
	output logic                                   samp_ready_o,
	output logic [7:0]                             samp_chan_o,
	input  wire logic [63:0]                       samp_data_i,
	input  wire logic                              evt_valid_i,
	output logic                                   evt_ready_o,
	input  wire asp_pkg::asp_evt_t                 evt_i,
	output logic                                   word_valid_o,
	input  wire logic                              word_ready_i,
	output logic [15:0]                            word_data_o,
	output logic                                   word_last_o,
	output logic                                   busy_o,
	output logic                                   done_o,
	output logic                                   len_trunc_o
);

	localparam logic [31:0] MAX_BITS = 32'(MAX_WORDS) * 32'(`ASP_WORD_W);
	localparam int          CH_W     = (NCH > 1) ? $clog2(NCH) : 1;

	asp_pkg::asp_state_t              st_r;
	asp_pkg::asp_state_t              st_nxt;
	asp_pkg::asp_chan_cfg_t [NCH-1:0] cfg_r;
	asp_pkg::asp_chan_cfg_t [NCH-1:0] cfg_nxt;
	asp_pkg::asp_disc_cfg_t           dcfg_r;
	asp_pkg::asp_disc_cfg_t           dcfg_nxt;
	logic [NCH-1:0]                   en_r;
	logic [NCH-1:0]                   en_nxt;
	logic [1:0]                       mode_r;
	logic [1:0]                       mode_nxt;
	logic                             disc_r;
	logic                             disc_nxt;
	logic [15:0]                      nsched_r;
	logic [15:0]                      nsched_nxt;
	logic [CH_W-1:0]                  ch_r;
	logic [CH_W-1:0]                  ch_nxt;
	logic [15:0]                      s_r;
	logic [15:0]                      s_nxt;
	logic [15:0]                      sched_r;
	logic [15:0]                      sched_nxt;
	logic [31:0]                      bits_r;
	logic [31:0]                      bits_nxt;
	logic                             trunc_r;
	logic                             trunc_nxt;
	logic                             done_r;
	logic                             done_nxt;

	logic [6:0]       w_g [NCH];
	logic [6:0]       nb_g [NCH];
	logic [31:0]      sbits_g [NCH];
	logic [NCH-1:0]   incl_g;
	logic [3:0]       kmax;
	logic [7:0]       totchan;
	logic [31:0]      sched_bits;
	logic [15:0]      s_one;
	logic [15:0]      s_max;
	logic             last_ch;
	logic             tail_none;
	logic [31:0]      bits_acc;

	logic             pk_valid;
	logic             pk_ready;
	logic [63:0]      pk_data;
	logic [6:0]       pk_bits;
	logic             pk_flush;
	logic             pk_empty;
	logic [63:0]      samp_fmt;
	logic [63:0]      samp_mask;
	logic [31:0]      st_mask;
	logic [31:0]      csw;

	assign s_one   = s_r + 16'h0001;
	assign last_ch = (ch_r == CH_W'(NCH - 1));
	assign tail_none = (((incl_g >> ch_r) >> 1) == '0);

	// Per-subchannel width, slot size, membership and schedule bits
	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_ch
			assign w_g[g] = (cfg_r[g].length == `ASP_LEN_FULL) ? `ASP_LEN_FULL_W
				: {1'b0, cfg_r[g].length};
			assign nb_g[g] = mode_r[`ASP_MODE_PACK]
				? ((w_g[g] + `ASP_PAD_ROUND) & `ASP_PAD_MASK) : w_g[g];
			assign incl_g[g] = en_r[g]
				&& ((s_one & ((16'h0001 << cfg_r[g].factor) - 16'h0001)) == 16'h0000);
			assign sbits_g[g] = en_r[g]
				? (32'(nb_g[g]) << (kmax - cfg_r[g].factor)) : 32'h0;
		end
	endgenerate

	// Slowest factor, subchannel count and bits per schedule
	always_comb
	begin
		kmax       = 4'h0;
		totchan    = 8'h00;
		sched_bits = 32'h0;
		for (int i = 0; i < NCH; i++)
		begin
			if (en_r[i] && (cfg_r[i].factor > kmax))
				kmax = cfg_r[i].factor;
			totchan    = totchan + {7'h00, en_r[i]};
			sched_bits = sched_bits + sbits_g[i];
		end
	end

	assign s_max = (16'h0001 << kmax) - 16'h0001;

	// Sample alignment for current subchannel
	assign samp_mask = (w_g[ch_r] == `ASP_LEN_FULL_W) ? '1
		: ((64'h1 << w_g[ch_r]) - 64'h1);
	always_comb
	begin
		samp_fmt = samp_data_i & samp_mask;
		if (mode_r == `ASP_MODE_LSBPAD)
			samp_fmt = samp_fmt << (nb_g[ch_r] - w_g[ch_r]);
	end

	assign st_mask = (dcfg_r.length == `ASP_DLEN_FULL) ? '1
		: ((32'h1 << dcfg_r.length) - 32'h1);

	assign csw = {`ASP_CSW_RSV, cfg_r[ch_r].factor, totchan, 8'(32'(ch_r) + 1),
		cfg_r[ch_r].length, mode_r};

	// Source selection for the bit packer
	always_comb
	begin
		pk_valid = 1'b0;
		pk_data  = 64'h0;
		pk_bits  = `ASP_CSW_BITS;
		case (st_r)
			asp_pkg::ASP_S_CSW:
			begin
				pk_valid = disc_r || en_r[ch_r];
				pk_data  = disc_r ? {32'h0, `ASP_DCSW_RSV, dcfg_r.length, dcfg_r.mode}
					: {32'h0, csw};
			end
			asp_pkg::ASP_S_SAMP:
			begin
				pk_valid = incl_g[ch_r] && samp_valid_i;
				pk_data  = samp_fmt;
				pk_bits  = nb_g[ch_r];
			end
			asp_pkg::ASP_S_STAMP:
			begin
				pk_valid = evt_valid_i;
				pk_data  = evt_i.stamp;
				pk_bits  = `ASP_TS_BITS;
			end
			asp_pkg::ASP_S_STATE:
			begin
				pk_valid = evt_valid_i;
				pk_data  = {32'h0, evt_i.states & st_mask};
				pk_bits  = `ASP_EVT_BITS;
			end
			default:
			begin
				pk_valid = 1'b0;
			end
		endcase
	end

	assign samp_ready_o = (st_r == asp_pkg::ASP_S_SAMP) && incl_g[ch_r] && pk_ready;
	assign samp_chan_o  = 8'(ch_r);
	assign evt_ready_o  = (st_r == asp_pkg::ASP_S_STATE) && pk_ready;
	assign pk_flush     = (st_r == asp_pkg::ASP_S_FLUSH);
	assign busy_o       = (st_r != asp_pkg::ASP_S_IDLE);
	assign done_o       = done_r;
	assign len_trunc_o  = trunc_r;
	assign bits_acc     = bits_r + ((pk_valid && pk_ready) ? 32'(pk_bits) : 32'h0);

	// Sequencer
	always_comb
	begin
		st_nxt     = st_r;
		cfg_nxt    = cfg_r;
		dcfg_nxt   = dcfg_r;
		en_nxt     = en_r;
		mode_nxt   = mode_r;
		disc_nxt   = disc_r;
		nsched_nxt = nsched_r;
		ch_nxt     = ch_r;
		s_nxt      = s_r;
		sched_nxt  = sched_r;
		bits_nxt   = bits_acc;
		trunc_nxt  = trunc_r;
		done_nxt   = 1'b0;
		case (st_r)
			asp_pkg::ASP_S_IDLE:
			begin
				bits_nxt = bits_r;
				if (start_i)
				begin
					cfg_nxt    = chan_cfg_i;
					dcfg_nxt   = disc_cfg_i;
					en_nxt     = chan_en_i;
					mode_nxt   = mode_i;
					disc_nxt   = discrete_i;
					nsched_nxt = sched_cnt_i;
					ch_nxt     = '0;
					s_nxt      = 16'h0000;
					sched_nxt  = 16'h0000;
					bits_nxt   = 32'h0;
					trunc_nxt  = 1'b0;
					st_nxt     = asp_pkg::ASP_S_CSW;
				end
			end
			asp_pkg::ASP_S_CSW:
			begin
				if (disc_r)
				begin
					if (pk_ready)
						st_nxt = asp_pkg::ASP_S_STAMP;
				end
				else if (!en_r[ch_r] || pk_ready)
				begin
					ch_nxt = last_ch ? '0 : ch_r + CH_W'(1);
					if (last_ch)
						st_nxt = (totchan == 8'h00) ? asp_pkg::ASP_S_FLUSH
							: asp_pkg::ASP_S_SAMP;
				end
			end
			asp_pkg::ASP_S_SAMP:
			begin
				if (!incl_g[ch_r] || (samp_valid_i && pk_ready))
				begin
					ch_nxt = tail_none ? '0 : ch_r + CH_W'(1);
					if (tail_none)
					begin
						s_nxt = (s_r == s_max) ? 16'h0000 : s_one;
						if (s_r == s_max)
						begin
							sched_nxt = sched_r + 16'h0001;
							if ((sched_r + 16'h0001) >= nsched_r)
								st_nxt = asp_pkg::ASP_S_FLUSH;
							else if ((bits_acc + sched_bits + `ASP_WORD_W) > MAX_BITS)
							begin
								trunc_nxt = 1'b1;
								st_nxt    = asp_pkg::ASP_S_FLUSH;
							end
						end
					end
				end
			end
			asp_pkg::ASP_S_STAMP:
			begin
				if (evt_valid_i && pk_ready)
					st_nxt = asp_pkg::ASP_S_STATE;
			end
			asp_pkg::ASP_S_STATE:
			begin
				if (evt_valid_i && pk_ready)
					st_nxt = evt_i.last ? asp_pkg::ASP_S_FLUSH : asp_pkg::ASP_S_STAMP;
			end
			asp_pkg::ASP_S_FLUSH:
			begin
				if (pk_empty)
				begin
					done_nxt = 1'b1;
					st_nxt   = asp_pkg::ASP_S_IDLE;
				end
			end
			default:
			begin
				st_nxt = asp_pkg::ASP_S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_r     <= asp_pkg::ASP_S_IDLE;
			cfg_r    <= '0;
			dcfg_r   <= '0;
			en_r     <= '0;
			mode_r   <= 2'h0;
			disc_r   <= 1'b0;
			nsched_r <= 16'h0000;
			ch_r     <= '0;
			s_r      <= 16'h0000;
			sched_r  <= 16'h0000;
			bits_r   <= 32'h0;
			trunc_r  <= 1'b0;
			done_r   <= 1'b0;
		end
		else
		begin
			st_r     <= st_nxt;
			cfg_r    <= cfg_nxt;
			dcfg_r   <= dcfg_nxt;
			en_r     <= en_nxt;
			mode_r   <= mode_nxt;
			disc_r   <= disc_nxt;
			nsched_r <= nsched_nxt;
			ch_r     <= ch_nxt;
			s_r      <= s_nxt;
			sched_r  <= sched_nxt;
			bits_r   <= bits_nxt;
			trunc_r  <= trunc_nxt;
			done_r   <= done_nxt;
		end
	end

	asp_bit_packer u_pack (
		.clk_sys_i   (clk_sys_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (pk_valid),
		.in_ready_o  (pk_ready),
		.in_data_i   (pk_data),
		.in_bits_i   (pk_bits),
		.flush_i     (pk_flush),
		.out_valid_o (word_valid_o),
		.out_ready_i (word_ready_i),
		.out_data_o  (word_data_o),
		.out_last_o  (word_last_o),
		.empty_o     (pk_empty)
	);

endmodule : asp_packer

// file: bench/asp_packer_sva.sv
// Port checker for the packet body formatter
`timescale 1ns/1ps
module asp_packer_sva #(
	parameter int NCH       = 8,
	parameter int MAX_WORDS = 65536
) (
	input wire logic        clk_sys_i,
	input wire logic        nrst_i,
	input wire logic        start_i,
	input wire logic        samp_ready_o,
	input wire logic [7:0]  samp_chan_o,
	input wire logic        evt_ready_o,
	input wire logic        word_valid_o,
	input wire logic        word_ready_i,
	input wire logic [15:0] word_data_o,
	input wire logic        word_last_o,
	input wire logic        busy_o,
	input wire logic        done_o,
	input wire logic        len_trunc_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	start_busy_a: assert property (start_i && !busy_o |=> busy_o)
		else $error("start did not raise busy");
	word_hold_a: assert property (word_valid_o && !word_ready_i |=>
		word_valid_o && $stable(word_data_o) && $stable(word_last_o))
		else $error("body word changed while stalled");
	last_valid_a: assert property (word_last_o |-> word_valid_o)
		else $error("last flag without valid word");
	last_done_a: assert property (word_valid_o && word_ready_i && word_last_o |-> ##[1:8] done_o)
		else $error("no done after last word");
	done_pulse_a: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
	idle_quiet_a: assert property (!busy_o |-> !word_valid_o && !samp_ready_o && !evt_ready_o)
		else $error("activity while idle");
	chan_range_a: assert property (samp_ready_o |-> samp_chan_o < NCH)
		else $error("sample channel out of range");
	trunc_hold_a: assert property (!busy_o && !start_i |=> $stable(len_trunc_o))
		else $error("truncation flag moved while idle");
	event_only_a: assert property (evt_ready_o |-> busy_o && !samp_ready_o)
		else $error("event taken during analog body");
	cover property (len_trunc_o && done_o);
	cover property (evt_ready_o);
	cover property (word_valid_o && !word_ready_i);
endmodule : asp_packer_sva

bind asp_packer asp_packer_sva #(.NCH(NCH), .MAX_WORDS(MAX_WORDS)) u_sva (
	.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .start_i(start_i),
	.samp_ready_o(samp_ready_o), .samp_chan_o(samp_chan_o), .evt_ready_o(evt_ready_o),
	.word_valid_o(word_valid_o), .word_ready_i(word_ready_i), .word_data_o(word_data_o),
	.word_last_o(word_last_o), .busy_o(busy_o), .done_o(done_o), .len_trunc_o(len_trunc_o));

// file: bench/asp_word_sink.sv
// Partner model: body word store with stalls
`timescale 1ns/1ps
module asp_word_sink (
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	input  wire logic        slow_i,
	input  wire logic        word_valid_i,
	input  wire logic [15:0] word_data_i,
	input  wire logic        word_last_i,
	output logic             word_ready_o
);
	logic [16:0] got[$];
	int          tick = 0;
	initial word_ready_o = 1'b0;
	always @(posedge clk_sys_i)
		if (word_valid_i && word_ready_o) got.push_back({word_last_i, word_data_i});
	always @(negedge clk_sys_i)
	begin
		tick = tick + 1;
		word_ready_o = nrst_i && (!slow_i || tick % 3 == 0);
	end
endmodule : asp_word_sink

// file: bench/asp_packer_tb.sv
// Self-checking bench for the packet body formatter
`timescale 1ns/1ps
module asp_packer_tb;
	localparam int MAXW = 64;
	logic clk_sys_i = 1'b0, nrst_i = 1'b0, start_i = 1'b0, discrete_i = 1'b0, slow = 1'b0;
	logic samp_valid_i = 1'b0, evt_valid_i = 1'b0, took = 1'b0;
	logic [1:0] mode_i = 2'h0;
	logic [7:0] chan_en_i = 8'h01, samp_chan_o;
	asp_pkg::asp_chan_cfg_t [7:0] chan_cfg_i = '0;
	logic [15:0] sched_cnt_i = 16'h0001, word_data_o;
	asp_pkg::asp_disc_cfg_t disc_cfg_i = '0;
	logic [63:0] samp_data_i = 64'h0;
	asp_pkg::asp_evt_t evt_i = '0;
	logic samp_ready_o, evt_ready_o, word_valid_o, word_ready_i, word_last_o, busy_o;
	logic done_o, len_trunc_o;
	int err_total = 0, comparisons = 0, seed = 32'h5b7c, sb, nsch, kmax;
	bit bq[$];
	logic [71:0] log_q[$];
	logic [15:0] exp_q[$];

	always #2.5 clk_sys_i = ~clk_sys_i;

	asp_packer #(.NCH(8), .MAX_WORDS(MAXW)) DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.start_i(start_i), .discrete_i(discrete_i), .mode_i(mode_i), .chan_en_i(chan_en_i),
		.chan_cfg_i(chan_cfg_i), .sched_cnt_i(sched_cnt_i), .disc_cfg_i(disc_cfg_i),
		.samp_valid_i(samp_valid_i), .samp_ready_o(samp_ready_o), .samp_chan_o(samp_chan_o),
		.samp_data_i(samp_data_i), .evt_valid_i(evt_valid_i), .evt_ready_o(evt_ready_o),
		.evt_i(evt_i), .word_valid_o(word_valid_o), .word_ready_i(word_ready_i),
		.word_data_o(word_data_o), .word_last_o(word_last_o), .busy_o(busy_o),
		.done_o(done_o), .len_trunc_o(len_trunc_o));

	asp_word_sink sink (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .slow_i(slow),
		.word_valid_i(word_valid_o), .word_data_i(word_data_o), .word_last_i(word_last_o),
		.word_ready_o(word_ready_i));

	// Sample source log and random stalls
	always @(posedge clk_sys_i)
	begin
		took = samp_valid_i && samp_ready_o;
		if (took) log_q.push_back({samp_chan_o, samp_data_i});
	end
	always @(negedge clk_sys_i)
		if (!samp_valid_i || took)
		begin
			samp_valid_i = !discrete_i && ($random(seed) & 3) != 0;
			samp_data_i = {$random(seed), $random(seed)};
		end

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
		comparisons++;
		if (seen !== want)
		begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", what, want, seen);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	task automatic put(input logic [63:0] v, input int n);
		for (int b = 0; b < n; b++) bq.push_back(v[b]);
	endtask : put

	task automatic run();
		int t;
		log_q.delete();
		sink.got.delete();
		start_i = 1'b1;
		@(negedge clk_sys_i) start_i = 1'b0;
		check("busy", busy_o, 1'b1);
		t = 0;
		while (!done_o && t < 20000)
		begin
			@(negedge clk_sys_i);
			t++;
		end
		if (!done_o)
		begin
			err_total++;
			tally_and_finish();
		end
		check("idle", busy_o, 1'b0);
	endtask : run

	task automatic body();
		logic [15:0] w;
		exp_q.delete();
		while (bq.size() % 16 != 0) bq.push_back(1'b0);
		while (bq.size() > 0)
		begin
			for (int b = 0; b < 16; b++) w[b] = bq.pop_front();
			exp_q.push_back(w);
		end
		check("word count", sink.got.size(), exp_q.size());
		foreach (exp_q[j])
			if (j < sink.got.size())
			begin
				check("body word", sink.got[j][15:0], exp_q[j]);
				check("last flag", sink.got[j][16], j == exp_q.size() - 1);
			end
	endtask : body

	// One schedule walk: sizes it, or emits it from the log
	task automatic sched(input bit emit);
		int w, sl;
		logic [71:0] d;
		for (int s = 1; s <= (1 << kmax); s++)
			for (int i = 0; i < 8; i++)
				if (chan_en_i[i] && s % (1 << chan_cfg_i[i].factor) == 0)
				begin
					w = chan_cfg_i[i].length == 6'h00 ? 64 : chan_cfg_i[i].length;
					sl = mode_i[0] ? (w + 15) / 16 * 16 : w;
					sb += sl;
					if (emit)
					begin
						check("samples left", log_q.size() > 0, 1);
						d = log_q.pop_front();
						check("sample channel", d[71:64], i);
						if (mode_i == 2'h1) put(64'h0, sl - w);
						put(d[63:0], w);
						if (mode_i != 2'h1) put(64'h0, sl - w);
					end
				end
	endtask : sched

	task automatic ana();
		int tot, sc;
		run();
		kmax = 0;
		tot = 0;
		sb = 0;
		foreach (chan_en_i[i])
			if (chan_en_i[i])
			begin
				tot++;
				if (chan_cfg_i[i].factor > kmax) kmax = chan_cfg_i[i].factor;
			end
		for (int i = 0; i < 8; i++)
			if (chan_en_i[i])
				put({4'h0, chan_cfg_i[i].factor, 8'(tot), 8'(i + 1), chan_cfg_i[i].length, mode_i}, 32);
		sched(1'b0);
		sc = sched_cnt_i == 16'h0000 ? 1 : sched_cnt_i;
		nsch = 1;
		while (nsch < sc && 32 * tot + sb * (nsch + 1) + 16 <= MAXW * 16) nsch++;
		for (int r = 0; r < nsch; r++) sched(1'b1);
		check("extra samples", log_q.size(), 0);
		check("length flag", len_trunc_o, nsch < sc);
		body();
	endtask : ana

	task automatic evts(input int n, input logic [31:0] m);
		int t;
		for (int e = 0; e < n; e++)
		begin
			evt_i = '{stamp: {$random(seed), $random(seed)}, states: $random(seed), last: e == n - 1};
			put(evt_i.stamp, 64);
			put(evt_i.states & m, 32);
			evt_valid_i = 1'b1;
			t = 0;
			while (!evt_ready_o && t < 5000)
			begin
				@(negedge clk_sys_i);
				t++;
			end
			if (!evt_ready_o)
			begin
				err_total++;
				tally_and_finish();
			end
			@(negedge clk_sys_i);
		end
		evt_valid_i = 1'b0;
	endtask : evts

	initial
	begin
		repeat (16) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		for (int r = 0; r < 9; r++)
		begin
			slow = r[0];
			mode_i = 2'(r);
			chan_en_i = r == 0 ? 8'h01 : 8'($random(seed)) | 8'h01;
			sched_cnt_i = r == 8 ? 16'h0064 : 16'(r % 3);
			foreach (chan_cfg_i[i])
				chan_cfg_i[i] = '{factor: 4'($random(seed) & 3),
					length: r == 0 ? 6'h10 : (r == 1 && i == 0 ? 6'h00 : 6'(1 + ($random(seed) & 15)))};
			ana();
		end
		discrete_i = 1'b1;
		for (int d = 0; d < 2; d++)
		begin
			disc_cfg_i = '{mode: 3'(d + 1), length: d ? 5'h00 : 5'h05};
			put({24'h0, disc_cfg_i.length, disc_cfg_i.mode}, 32);
			fork
				run();
				evts(3, d ? 32'hFFFFFFFF : 32'h0000001F);
			join
			body();
		end
		tally_and_finish();
	end
endmodule : asp_packer_tb
